// ### disp_drv_pkg.sv
// Shared constants for the serial display output driver.
// Assumes nothing beyond a SystemVerilog compiler.
package disp_drv_pkg;
	localparam int unsigned NUM_OUTPUTS = 32;
	localparam int unsigned FIFO_DEPTH = 16;
	localparam int unsigned SYNC_STAGES = 3;
	localparam logic [31:0] LATCH_RESET = 32'h0000_0000;
	localparam logic BLANK_RESET = 1'b1;
endpackage

// ### disp_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock domain; depth is a power of two.
`timescale 1ns/1ps
module disp_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
	logic push, pop;

	assign in_ready = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
	assign out_valid = wr_reg != rd_reg;
	assign out_data = mem[rd_reg[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		wr_next = wr_reg + (AW+1)'(push);
		rd_next = rd_reg + (AW+1)'(pop);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wr_reg <= '0;
			rd_reg <= '0;
		end else begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
		end
		if (push) begin
			mem[wr_reg[AW-1:0]] <= in_data;
		end
	end
endmodule

// ### disp_drv.sv
// Overview of operation
// R1: Shift only while frame enable high
// R2: Rising serial clock captures data, shifts
// R3: Enable falling latches register to outputs
// R4: Outputs hold old pattern during transfer
// R5: Serial out changes on falling clock
// R6: Blank high forces all outputs off
// R7: Latched one turns output on
// R8: First bit shifted drives output one
// R9: Host clears by shifting 32 zeroes
// R10: Blank independent of shifting and latching
// R11: 32 stages, serial out from last
//
// Serial display driver: shift register on the host's serial clock,
// enable and blank pins brought into clk through three flops each.
// Assumes clk and the serial clock unrelated in rate and phase, and frames
// separated by at least six clk cycles of enable low.
`timescale 1ns/1ps
module disp_drv #(
	parameter int NUM_OUT = disp_drv_pkg::NUM_OUTPUTS,
	parameter int DEPTH = disp_drv_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic sclk,
	input wire logic frame_en,
	input wire logic ser_in,
	input wire logic blank,
	output logic ser_out,
	output logic [NUM_OUT-1:0] disp_out,
	output logic overflow
);
	localparam int SYNC = disp_drv_pkg::SYNC_STAGES;

	// Link domain: shift register and serial output
	logic [NUM_OUT-1:0] shift_reg;
	logic [NUM_OUT-1:0] shift_next;
	logic ser_out_reg;
	logic ser_out_next;
	// Pin synchronisers and settled pin levels in the clk domain
	logic [SYNC-1:0] en_sync_reg;
	logic [SYNC-1:0] en_sync_next;
	logic [SYNC-1:0] blank_sync_reg;
	logic [SYNC-1:0] blank_sync_next;
	logic en_state_reg;
	logic en_state_next;
	logic blank_state_reg;
	logic blank_state_next;
	logic frame_done;
	// Frame buffer and display state
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [NUM_OUT-1:0] fifo_out_data;
	logic [NUM_OUT-1:0] latch_reg;
	logic [NUM_OUT-1:0] latch_next;
	logic [NUM_OUT-1:0] out_reg;
	logic [NUM_OUT-1:0] out_next;
	logic ovf_reg;
	logic ovf_next;

	// A change counts once the second and third stage agree
	function automatic logic sync_settled(input logic [SYNC-1:0] s);
		return s[SYNC-2] == s[SYNC-1];
	endfunction

	// R1: edges outside a frame leave the register untouched
	// R2 R8: new bit enters on top, first bit ends in bit zero
	always_comb begin
		shift_next = shift_reg;
		if (frame_en) begin
			shift_next = {ser_in, shift_reg[NUM_OUT-1:1]};
		end
	end

	// No reset: cleared by the host flushing zeroes
	always_ff @(posedge sclk) begin
		shift_reg <= shift_next;
	end

	// R5 R11: last stage launched on the falling edge
	always_comb begin
		ser_out_next = shift_reg[0];
	end

	always_ff @(negedge sclk) begin
		ser_out_reg <= ser_out_next;
	end

	always_comb begin
		en_sync_next = {en_sync_reg[SYNC-2:0], frame_en};
		blank_sync_next = {blank_sync_reg[SYNC-2:0], blank};
	end

	// Synchronisers carry only the pin level, so no reset
	always_ff @(posedge clk) begin
		en_sync_reg <= en_sync_next;
		blank_sync_reg <= blank_sync_next;
	end

	always_comb begin
		en_state_next = en_state_reg;
		blank_state_next = blank_state_reg;
		if (sync_settled(en_sync_reg)) begin
			en_state_next = en_sync_reg[SYNC-1];
		end
		if (sync_settled(blank_sync_reg)) begin
			blank_state_next = blank_sync_reg[SYNC-1];
		end
		// R3: settled fall of the enable closes a frame
		frame_done = en_state_reg && !en_state_next;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			en_state_reg <= 1'b0;
			blank_state_reg <= disp_drv_pkg::BLANK_RESET;
		end else begin
			en_state_reg <= en_state_next;
			blank_state_reg <= blank_state_next;
		end
	end

	// Shift register is frozen while the enable is low, so it is taken
	// as a quasi-static word qualified by the synchronised enable fall
	disp_fifo #(
		.WIDTH(NUM_OUT),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk(clk),
		.srst(srst),
		.in_data(shift_reg),
		.in_valid(frame_done),
		.in_ready(fifo_in_ready),
		.out_data(fifo_out_data),
		.out_valid(fifo_out_valid),
		.out_ready(1'b1)
	);

	always_comb begin
		latch_next = latch_reg;
		// R4: only a completed frame replaces the pattern
		if (fifo_out_valid) begin
			latch_next = fifo_out_data;
		end
		// R7: a one in the latch turns its output on
		out_next = latch_next;
		// R6 R10: blank masks outputs, never touches the latch
		if (blank_state_next) begin
			out_next = '0;
		end
		// Sticky: a frame lost to a full buffer stays visible
		ovf_next = ovf_reg | (frame_done & ~fifo_in_ready);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			latch_reg <= NUM_OUT'(disp_drv_pkg::LATCH_RESET);
			out_reg <= '0;
			ovf_reg <= 1'b0;
		end else begin
			latch_reg <= latch_next;
			out_reg <= out_next;
			ovf_reg <= ovf_next;
		end
	end

	assign ser_out = ser_out_reg;
	assign disp_out = out_reg;
	assign overflow = ovf_reg;
endmodule

// ### disp_drv_checker.sv
// Port checks for disp_drv.
// Assumes clk and srst of the system domain.
`timescale 1ns/1ps
module disp_drv_checker (
	input wire logic clk,
	input wire logic srst,
	input wire logic frame_en,
	input wire logic blank,
	input wire logic [31:0] disp_out,
	input wire logic overflow
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	blank_forces_off_a: assert property (blank[*5] |-> disp_out == 0)
		else $error("outputs on while blanked");
	hold_in_xfer_a: assert property ((frame_en && !blank)[*8] |=>
		$stable(disp_out)) else $error("outputs moved in transfer");
	reset_clears_out_a: assert property (disable iff (1'b0)
		srst |=> disp_out == '0 && !overflow)
		else $error("outputs not cleared by reset");
	blank_quick_a: assert property ($rose(blank) |->
		##[1:5] disp_out == '0) else $error("blank not applied in time");
	no_frame_lost_a: assert property (!overflow)
		else $error("frame lost to full buffer");
	idle_hold_a: assert property ((!frame_en && !blank)[*8] |=>
		$stable(disp_out)) else $error("outputs moved while idle");
	cover property ($fell(frame_en));
	cover property ($rose(blank));
	cover property ($changed(disp_out));
endmodule
bind disp_drv disp_drv_checker chk (.clk, .srst, .frame_en, .blank,
	.disp_out, .overflow);

// ### disp_host.sv
// Host model driving the serial link.
// Assumes the bench calls send; sclk idles low between frames.
`timescale 1ns/1ps
module disp_host (
	output logic sclk,
	output logic frame_en,
	output logic ser_in
);
	initial begin
		sclk = 0;
		frame_en = 0;
		ser_in = 0;
	end
	task automatic send(input logic [31:0] w, input int n, input bit en);
		frame_en = en;
		#150;
		for (int i = 0; i < n; i++) begin
			ser_in = w[i];
			#15 sclk = 1;
			#15 sclk = 0;
		end
		// Released data line must not look valid
		ser_in = ~ser_in;
		#150 frame_en = 0;
		#400;
	endtask
endmodule

// ### tb_disp_drv.sv
// Bench for disp_drv: host model frames, queued expected outputs.
// Assumes the host model makes the link clock.
`timescale 1ns/1ps
module tb_disp_drv;
	logic clk = 0, srst = 1, blank = 0, sclk, frame_en, ser_in, ser_out;
	logic [31:0] disp_out, sr = 0, last = 0, seen = 0, seed = 32'h9E1CD35C;
	logic [31:0] q[$];
	logic ovf;
	int n_fail = 0, checks_done = 0;
	disp_drv uut (.clk, .srst, .sclk, .frame_en, .ser_in, .blank, .ser_out,
		.disp_out, .overflow(ovf));
	disp_host host (.sclk, .frame_en, .ser_in);
	initial forever #25 clk = ~clk;
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s;
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic cmp_ser(input logic e, a);
		checks_done++;
		if (e !== a) begin
			n_fail++;
			$display("MISMATCH %0t %h %h", $time, e, a);
		end
	endtask
	task automatic cmp_out(input logic [31:0] e, a);
		checks_done++;
		if (e !== a) begin
			n_fail++;
			$display("MISMATCH %0t %h %h", $time, e, a);
		end
	endtask
	task automatic finish_test;
		if (n_fail == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic frame(input int n, input bit en, input bit zero);
		seed = xorshift(seed);
		for (int i = 0; i < n && en; i++) sr = {seed[i] & !zero, sr[31:1]};
		if (!blank && sr !== last) q.push_back(sr);
		last = sr;
		host.send(zero ? 32'h0 : seed, n, en);
		cmp_ser(sr[0], ser_out);
	endtask
	// Sampled away from the launching edge
	always @(negedge clk) begin
		if (!srst && disp_out !== seen) begin
			seen = disp_out;
			cmp_out(q.size() ? q.pop_front() : ~seen, seen);
		end
	end
	initial begin
		#1000000;
		n_fail++;
		finish_test;
	end
	initial begin
		repeat (10) @(negedge clk);
		srst = 0;
		frame(32, 1, 1);
		repeat (5) frame(32, 1, 0);
		frame(8, 0, 0);
		frame(8, 1, 0);
		@(negedge clk);
		if (last) q.push_back(0);
		blank = 1;
		frame(32, 1, 0);
		if (last) q.push_back(last);
		@(negedge clk);
		blank = 0;
		repeat (20) @(negedge clk);
		cmp_out(0, q.size());
		cmp_ser(0, ovf);
		finish_test;
	end
endmodule
